// File: design/rsc_pkg.sv
// Constants and types shared by the reset start-up and cause flag block
package rsc_pkg;

    // ========================================
    // Timing
    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned PLL_LOCK_TIME_NS = 2000;
    localparam int unsigned PLL_LOCK_CYCLES =
        (PLL_LOCK_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned OSC_STARTUP_CYCLES = 1024;
    localparam int unsigned POWERUP_RC_CYCLES = 64;

    // ========================================
    // Oscillator selection codes
    localparam logic [2:0] OSC_LOW_POWER_CRYSTAL = 3'h0;
    localparam logic [2:0] OSC_MEDIUM_SPEED_CRYSTAL = 3'h1;
    localparam logic [2:0] OSC_HIGH_SPEED_CRYSTAL = 3'h2;
    localparam logic [2:0] OSC_HIGH_SPEED_CRYSTAL_WITH_PLL = 3'h3;

    // ========================================
    // Cause flag positions
    localparam int unsigned NUM_FLAGS = 13;
    localparam int unsigned IDX_DEEP_SLEEP = 0;
    localparam int unsigned IDX_EXTERNAL_RESET = 1;
    localparam int unsigned IDX_RESET_INSTR = 2;
    localparam int unsigned IDX_WATCHDOG_TIMEOUT = 3;
    localparam int unsigned IDX_POWER_DOWN = 4;
    localparam int unsigned IDX_IDLE = 5;
    localparam int unsigned IDX_CFG_MISMATCH = 6;
    localparam int unsigned IDX_CORE_BROWNOUT = 7;
    localparam int unsigned IDX_CORE_POWERON = 8;
    localparam int unsigned IDX_SUPPLY_BROWNOUT = 9;
    localparam int unsigned IDX_SUPPLY_POWERON = 10;
    localparam int unsigned IDX_BATTERY_POWERON = 11;
    localparam int unsigned IDX_BATTERY_MODE = 12;

    // ========================================
    // Flag reset value and event masks
    localparam logic [12:0] FLAGS_RST = 13'h0F90;
    localparam logic [12:0] SW_SET_MASK = 13'h07FF;
    localparam logic [12:0] SET_SUPPLY_POR = 13'h0790;
    localparam logic [12:0] CLR_SUPPLY_POR = 13'h006F;
    localparam logic [12:0] SET_SUPPLY_BOR = 13'h0210;
    localparam logic [12:0] CLR_SUPPLY_BOR = 13'h006C;
    localparam logic [12:0] SET_CORE_POR = 13'h0190;
    localparam logic [12:0] CLR_CORE_POR = 13'h006F;
    localparam logic [12:0] SET_CORE_BOR = 13'h0090;
    localparam logic [12:0] CLR_CORE_BOR = 13'h006C;
    localparam logic [12:0] SET_BATTERY = 13'h1791;
    localparam logic [12:0] CLR_BATTERY = 13'h006E;
    localparam logic [12:0] SET_DS_EXIT = 13'h0191;
    localparam logic [12:0] CLR_DS_EXIT = 13'h006E;
    localparam logic [12:0] SET_RDS_EXIT = 13'h0011;
    localparam logic [12:0] CLR_RDS_EXIT = 13'h01EE;
    localparam logic [12:0] SET_EXT = 13'h0002;
    localparam logic [12:0] SET_EXT_IDLE = 13'h0022;
    localparam logic [12:0] CLR_EXT_IDLE = 13'h0018;
    localparam logic [12:0] CLR_EXT_SLEEP = 13'h0038;
    localparam logic [12:0] SET_WDT = 13'h0008;
    localparam logic [12:0] SET_WDT_IDLE = 13'h0038;
    localparam logic [12:0] CLR_WDT_SLEEP = 13'h0030;
    localparam logic [12:0] SET_PD_IDLE = 13'h0030;
    localparam logic [12:0] CLR_WDT_ONLY = 13'h0008;
    localparam logic [12:0] CLR_SLEEP_ALL = 13'h0038;
    localparam logic [12:0] SET_PD_ONLY = 13'h0010;
    localparam logic [12:0] SET_RESET_INSTR = 13'h0004;
    localparam logic [12:0] SET_CFG_MISMATCH = 13'h0040;

    // ========================================
    // Program counter actions
    localparam logic [1:0] PC_HOLD = 2'h0;
    localparam logic [1:0] PC_CLEAR = 2'h1;
    localparam logic [1:0] PC_NEXT = 2'h2;
    localparam logic [1:0] PC_VECTOR = 2'h3;

    typedef enum logic [3:0] {
        ST_POWERUP = 4'h1,
        ST_OSC_WAIT = 4'h2,
        ST_PLL_WAIT = 4'h4,
        ST_RUN = 4'h8
    } rsc_state_e;

endpackage

// File: design/rsc_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rsc_sync2 #(
    parameter int unsigned W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    logic [W-1:0] dout_r;

    // ========================================
    // Stages
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= RST_VAL;
            dout_r <= RST_VAL;
        end else begin
            meta_r <= din;
            dout_r <= meta_r;
        end
    end

    assign dout = dout_r;
endmodule

// File: design/rsc_tick_counter.sv
// Down counter of qualified ticks with sticky done
`timescale 1ns/1ps
module rsc_tick_counter #(
    parameter int unsigned LEN = 1024,
    parameter int unsigned W = 11
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic restart,
    input wire logic tick,
    output logic done
);
    localparam logic [W-1:0] LEN_W = W'(LEN);
    localparam logic [W-1:0] ONE_W = W'(1);

    logic [W-1:0] cnt_r;
    logic done_r;
    logic last_tick;

    // ========================================
    // Count
    assign last_tick = tick && !done_r && (cnt_r == ONE_W);

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= LEN_W;
            done_r <= 1'b0;
        end else if (restart) begin
            cnt_r <= LEN_W;
            done_r <= 1'b0;
        end else if (tick && !done_r) begin
            cnt_r <= cnt_r - ONE_W;
            done_r <= last_tick;
        end
    end

    assign done = done_r;
endmodule

// File: design/rsc_reset_cause.sv
// Start-up delay sequencer and reset cause flags
`timescale 1ns/1ps

// What this block does
// - Hold 1024 oscillator edges after power-up delay
// - Oscillator wait only in crystal modes
// - Selection code 011 enables PLL wait
// - PLL lock wait follows oscillator wait
// - Power and soft resets force init, wakes leave registers
// - Watchdog wake does not reinitialise registers
// - Master clear in idle: clear PC, flags
// - Master clear in sleep: clear PC, flags
// - Watchdog in idle: next instruction, flags set
// - Watchdog in sleep: next, clear power flags
// - Interrupt from idle: vector or next
// - Interrupt from sleep without enable: next
// - Sleep and idle instructions update flags
// - Watchdog clear honours window setting
// - Battery mode sets deep sleep, battery mode flags
// - Retention exit sets deep sleep, clears core
// - Battery flags: hardware sets, software clears
// - Battery power-on flag set at power-up
// - Supply and core power-on flags distinct
// - Power-up timer on RC after power events
module rsc_reset_cause
    import rsc_pkg::*;
#(
    parameter int unsigned POWERUP_TIMER_LEN = POWERUP_RC_CYCLES,
    parameter int unsigned OST_LEN = OSC_STARTUP_CYCLES,
    parameter int unsigned PLL_LEN = PLL_LOCK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic osc_in,
    input wire logic rc_osc_in,
    input wire logic master_clear_pin_n,
    input wire logic [2:0] osc_select_field,
    input wire logic mode_idle,
    input wire logic mode_sleep,
    input wire logic global_irq_enable,
    input wire logic evt_supply_por,
    input wire logic evt_supply_bor,
    input wire logic evt_core_por,
    input wire logic evt_core_bor,
    input wire logic evt_battery_mode,
    input wire logic evt_deep_sleep_exit,
    input wire logic evt_retention_exit,
    input wire logic evt_pm_exit,
    input wire logic evt_wdt_timeout,
    input wire logic evt_irq_wake,
    input wire logic evt_reset_instr,
    input wire logic evt_cfg_mismatch,
    input wire logic instr_sleep,
    input wire logic instr_idle,
    input wire logic watchdog_clear_instr,
    input wire logic wdt_window_en,
    input wire logic wdt_in_safe_window,
    input wire logic sw_wr,
    input wire logic [12:0] sw_wr_data,
    output logic device_hold,
    output logic [12:0] cause_flags,
    output logic [1:0] pc_action,
    output logic pc_strobe,
    output logic regs_init,
    output logic regs_init_por
);
    rsc_state_e st_r;
    rsc_state_e st_nxt;
    logic [2:0] pin_s;
    logic [2:0] pin_prev_r;
    logic osc_rise, rc_rise, master_clear_pin_fall;
    logic powerup_timer_done, ost_done, pll_done;
    logic xtal_mode, pll_sel, pwr_evt;
    logic in_sleep, in_idle, in_run;
    logic master_clear_pin_run, master_clear_pin_idle, master_clear_pin_sleep;
    logic wdt_run, wdt_idle, wdt_sleep;
    logic irq_idle, irq_sleep, irq_vec, watchdog_clear_instr_ok;
    logic soft_rst, wake_next;
    logic [12:0] hw_set, hw_clr, sw_base;
    logic [12:0] flag_r, flag_nxt;
    logic [1:0] pc_action_r, pc_action_nxt;
    logic pc_strobe_r, regs_init_r, regs_init_por_r;

    // ========================================
    // Pin synchronisation and edges
    rsc_sync2 #(.W(3), .RST_VAL(3'h4)) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .din({master_clear_pin_n, rc_osc_in, osc_in}),
        .dout(pin_s)
    );

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pin_prev_r <= 3'h4;
        end else begin
            pin_prev_r <= pin_s;
        end
    end

    assign osc_rise = pin_s[0] && !pin_prev_r[0];
    assign rc_rise = pin_s[1] && !pin_prev_r[1];
    assign master_clear_pin_fall = !pin_s[2] && pin_prev_r[2];

    // ========================================
    // Start-up sequencing
    assign xtal_mode = (osc_select_field == OSC_LOW_POWER_CRYSTAL) ||
        (osc_select_field == OSC_MEDIUM_SPEED_CRYSTAL) ||
        (osc_select_field == OSC_HIGH_SPEED_CRYSTAL) ||
        (osc_select_field == OSC_HIGH_SPEED_CRYSTAL_WITH_PLL);
    assign pll_sel = (osc_select_field == OSC_HIGH_SPEED_CRYSTAL_WITH_PLL);
    assign pwr_evt = evt_supply_por || evt_supply_bor || evt_core_por ||
        evt_core_bor || evt_battery_mode || evt_deep_sleep_exit ||
        evt_retention_exit;

    rsc_tick_counter #(.LEN(POWERUP_TIMER_LEN), .W(13)) u_powerup_timer (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .restart(pwr_evt),
        .tick(rc_rise && (st_r == ST_POWERUP)),
        .done(powerup_timer_done)
    );

    rsc_tick_counter #(.LEN(OST_LEN), .W(13)) u_ost (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .restart(st_r != ST_OSC_WAIT),
        .tick(osc_rise),
        .done(ost_done)
    );

    rsc_tick_counter #(.LEN(PLL_LEN), .W(13)) u_pll (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .restart(st_r != ST_PLL_WAIT),
        .tick(1'b1),
        .done(pll_done)
    );

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_POWERUP: begin
                if (powerup_timer_done) begin
                    st_nxt = xtal_mode ? ST_OSC_WAIT :
                        (pll_sel ? ST_PLL_WAIT : ST_RUN);
                end
            end
            ST_OSC_WAIT: begin
                if (ost_done) begin
                    st_nxt = pll_sel ? ST_PLL_WAIT : ST_RUN;
                end
            end
            ST_PLL_WAIT: begin
                if (pll_done) begin
                    st_nxt = ST_RUN;
                end
            end
            ST_RUN: begin
                if (evt_pm_exit && xtal_mode) begin
                    st_nxt = ST_OSC_WAIT;
                end
            end
            default: st_nxt = ST_POWERUP;
        endcase
        if (pwr_evt) begin
            st_nxt = ST_POWERUP;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= ST_POWERUP;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign device_hold = (st_r != ST_RUN);

    // ========================================
    // Event qualification
    assign in_idle = mode_idle;
    assign in_sleep = mode_sleep && !mode_idle;
    assign in_run = !mode_idle && !mode_sleep;
    assign master_clear_pin_run = master_clear_pin_fall && in_run;
    assign master_clear_pin_idle = master_clear_pin_fall && in_idle;
    assign master_clear_pin_sleep = master_clear_pin_fall && in_sleep;
    assign wdt_run = evt_wdt_timeout && in_run;
    assign wdt_idle = evt_wdt_timeout && in_idle;
    assign wdt_sleep = evt_wdt_timeout && in_sleep;
    assign irq_idle = evt_irq_wake && in_idle;
    assign irq_sleep = evt_irq_wake && in_sleep;
    assign irq_vec = (irq_idle || irq_sleep) && global_irq_enable;
    assign watchdog_clear_instr_ok = watchdog_clear_instr &&
        (!wdt_window_en || wdt_in_safe_window);
    assign soft_rst = master_clear_pin_fall || wdt_run || evt_reset_instr ||
        evt_cfg_mismatch;
    assign wake_next = wdt_idle || wdt_sleep || instr_sleep ||
        instr_idle || watchdog_clear_instr ||
        ((irq_idle || irq_sleep) && !global_irq_enable);

    // ========================================
    // Cause flags
    assign hw_set = ({13{evt_supply_por}} & SET_SUPPLY_POR) |
        ({13{evt_supply_bor}} & SET_SUPPLY_BOR) |
        ({13{evt_core_por}} & SET_CORE_POR) |
        ({13{evt_core_bor}} & SET_CORE_BOR) |
        ({13{evt_battery_mode}} & SET_BATTERY) |
        ({13{evt_deep_sleep_exit}} & SET_DS_EXIT) |
        ({13{evt_retention_exit}} & SET_RDS_EXIT) |
        ({13{master_clear_pin_run || master_clear_pin_sleep}} & SET_EXT) |
        ({13{master_clear_pin_idle}} & SET_EXT_IDLE) |
        ({13{wdt_run || wdt_sleep}} & SET_WDT) |
        ({13{wdt_idle}} & SET_WDT_IDLE) |
        ({13{irq_idle || instr_idle}} & SET_PD_IDLE) |
        ({13{watchdog_clear_instr}} & SET_PD_ONLY) |
        ({13{evt_reset_instr}} & SET_RESET_INSTR) |
        ({13{evt_cfg_mismatch}} & SET_CFG_MISMATCH);

    assign hw_clr = ({13{evt_supply_por}} & CLR_SUPPLY_POR) |
        ({13{evt_supply_bor}} & CLR_SUPPLY_BOR) |
        ({13{evt_core_por}} & CLR_CORE_POR) |
        ({13{evt_core_bor}} & CLR_CORE_BOR) |
        ({13{evt_battery_mode}} & CLR_BATTERY) |
        ({13{evt_deep_sleep_exit}} & CLR_DS_EXIT) |
        ({13{evt_retention_exit}} & CLR_RDS_EXIT) |
        ({13{master_clear_pin_idle}} & CLR_EXT_IDLE) |
        ({13{master_clear_pin_sleep}} & CLR_EXT_SLEEP) |
        ({13{wdt_sleep}} & CLR_WDT_SLEEP) |
        ({13{irq_idle || instr_idle}} & CLR_WDT_ONLY) |
        ({13{irq_sleep || instr_sleep}} & CLR_SLEEP_ALL) |
        ({13{watchdog_clear_instr_ok}} & CLR_WDT_ONLY);

    // Software may not set the battery flags, only clear them
    assign sw_base = sw_wr ?
        ((sw_wr_data & SW_SET_MASK) | (flag_r & sw_wr_data & ~SW_SET_MASK)) :
        flag_r;
    assign flag_nxt = (sw_base & ~hw_clr) | hw_set;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            flag_r <= FLAGS_RST;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign cause_flags = flag_r;

    // ========================================
    // Program counter and register init requests
    assign pc_action_nxt = (pwr_evt || soft_rst) ? PC_CLEAR :
        (irq_vec ? PC_VECTOR : (wake_next ? PC_NEXT : PC_HOLD));

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            pc_action_r <= PC_CLEAR;
            pc_strobe_r <= 1'b0;
            regs_init_r <= 1'b1;
            regs_init_por_r <= 1'b1;
        end else begin
            pc_action_r <= pc_action_nxt;
            pc_strobe_r <= (pc_action_nxt != PC_HOLD);
            regs_init_r <= pwr_evt || soft_rst;
            regs_init_por_r <= pwr_evt;
        end
    end

    assign pc_action = pc_action_r;
    assign pc_strobe = pc_strobe_r;
    assign regs_init = regs_init_r;
    assign regs_init_por = regs_init_por_r;

    // ========================================
    // Checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);

    logic lone;
    assign lone = $onehot({pwr_evt, master_clear_pin_fall, evt_wdt_timeout,
        evt_irq_wake, evt_reset_instr, evt_cfg_mismatch, instr_sleep,
        instr_idle, watchdog_clear_instr}) && !sw_wr;

    chk_osc_wait_hold: assert property (
        (st_r == ST_OSC_WAIT && !ost_done && !pwr_evt) |=>
        (st_r == ST_OSC_WAIT))
        else $error("oscillator wait left early");
    chk_osc_wait_mode: assert property (
        (st_r == ST_OSC_WAIT) |-> xtal_mode)
        else $error("oscillator wait outside crystal mode");
    chk_pll_wait_sel: assert property (
        (st_r == ST_PLL_WAIT && !pwr_evt) |-> pll_sel)
        else $error("pll wait without pll selection");
    chk_pll_after_osc: assert property (
        $rose(st_r == ST_PLL_WAIT) |-> $past(st_r == ST_OSC_WAIT))
        else $error("pll wait not after oscillator wait");
    chk_wake_no_init: assert property (
        (lone && (evt_irq_wake || wdt_idle || wdt_sleep)) |=> !regs_init)
        else $error("wake reinitialised registers");
    chk_master_clear_pin_idle: assert property (
        (lone && master_clear_pin_idle) |=> (cause_flags[IDX_EXTERNAL_RESET] &&
        cause_flags[IDX_IDLE] && !cause_flags[IDX_WATCHDOG_TIMEOUT] &&
        !cause_flags[IDX_POWER_DOWN] && pc_action == PC_CLEAR))
        else $error("master clear in idle flags wrong");
    chk_wdt_sleep: assert property (
        (lone && wdt_sleep) |=> (cause_flags[IDX_WATCHDOG_TIMEOUT] &&
        !cause_flags[IDX_POWER_DOWN] && !cause_flags[IDX_IDLE] &&
        pc_action == PC_NEXT && pc_strobe))
        else $error("watchdog in sleep flags wrong");
    chk_watchdog_clear_instr_window: assert property (
        (lone && watchdog_clear_instr && wdt_window_en &&
        !wdt_in_safe_window) |=>
        (cause_flags[IDX_WATCHDOG_TIMEOUT] ==
        $past(cause_flags[IDX_WATCHDOG_TIMEOUT])))
        else $error("watchdog clear ignored window");
    chk_batt_sw_set: assert property (
        (sw_wr && !cause_flags[IDX_BATTERY_POWERON] &&
        !evt_supply_por && !evt_battery_mode) |=>
        !cause_flags[IDX_BATTERY_POWERON])
        else $error("software set battery flag");
    chk_run_release: assert property (
        $rose(st_r == ST_RUN) |-> $past(powerup_timer_done) &&
        (!xtal_mode || $past(ost_done) || $past(pll_done)))
        else $error("released before stages done");

    cov_pll_run: cover property (
        (st_r == ST_PLL_WAIT) ##1 (st_r == ST_RUN));
    cov_irq_vector: cover property (irq_vec ##1 (pc_action == PC_VECTOR));
    cov_retention: cover property (lone && evt_retention_exit);
endmodule

// File: bench/tb_rsc_reset_cause.sv
// Self-checking bench of the reset start-up and cause flag block
`timescale 1ns/1ps
module tb_rsc_reset_cause
    import rsc_pkg::*;
;
// ========================================
// Signals and expectation tables
localparam int PW = 4;
localparam int OL = 8;
localparam int PL = 5;
localparam logic [12:0] SM [0:6] = '{13'h0790, 13'h0210, 13'h0190,
    13'h0090, 13'h1791, 13'h0191, 13'h0011};
localparam logic [12:0] CM [0:6] = '{13'h006F, 13'h006C, 13'h006F,
    13'h006C, 13'h006E, 13'h006E, 13'h01EE};
localparam int EL [0:5] = '{8, 9, 16, 13, 12, 14};
logic clk_sys, sys_rst, osc_in, rc_osc_in, master_clear_pin_n, osc_run;
logic [2:0] osc_select_field;
logic mode_idle, mode_sleep, global_irq_enable;
logic wdt_window_en, wdt_in_safe_window;
logic [15:0] ev;
logic [12:0] sw_wr_data, cause_flags, ef;
logic device_hold, pc_strobe, regs_init, regs_init_por, ei, eq;
logic [1:0] pc_action, ep, es;
int compares, miscompares, seed, t;
int tc [0:7];

rsc_reset_cause #(.POWERUP_TIMER_LEN(PW), .OST_LEN(OL), .PLL_LEN(PL)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .osc_in(osc_in),
    .rc_osc_in(rc_osc_in), .master_clear_pin_n(master_clear_pin_n),
    .osc_select_field(osc_select_field), .mode_idle(mode_idle),
    .mode_sleep(mode_sleep), .global_irq_enable(global_irq_enable),
    .evt_supply_por(ev[0]), .evt_supply_bor(ev[1]), .evt_core_por(ev[2]),
    .evt_core_bor(ev[3]), .evt_battery_mode(ev[4]),
    .evt_deep_sleep_exit(ev[5]), .evt_retention_exit(ev[6]),
    .evt_pm_exit(ev[7]), .evt_wdt_timeout(ev[8]), .evt_irq_wake(ev[9]),
    .evt_reset_instr(ev[10]), .evt_cfg_mismatch(ev[11]),
    .instr_sleep(ev[12]), .instr_idle(ev[13]),
    .watchdog_clear_instr(ev[14]), .wdt_window_en(wdt_window_en),
    .wdt_in_safe_window(wdt_in_safe_window), .sw_wr(ev[15]),
    .sw_wr_data(sw_wr_data), .device_hold(device_hold),
    .cause_flags(cause_flags), .pc_action(pc_action),
    .pc_strobe(pc_strobe), .regs_init(regs_init),
    .regs_init_por(regs_init_por)
);

initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
end

always @(posedge clk_sys) begin
    #1;
    rc_osc_in <= sys_rst ? 1'b0 : ~rc_osc_in;
    osc_in <= (sys_rst || !osc_run) ? 1'b0 : ~osc_in;
end

// ========================================
// Compare, verdict and prediction
task automatic check(string nm, logic [12:0] seen, logic [12:0] exp);
    compares++;
    if (seen !== exp) begin
        miscompares++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask

task automatic close_out();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
        $display("SIMULATION PASSED");
    end else begin
        $display("SIMULATION FAILED");
    end
    $finish;
endtask

function automatic void predict(int e, logic [12:0] d);
    logic [12:0] s;
    logic [12:0] c;
    logic wk;
    wk = mode_idle | mode_sleep;
    s = 13'h0000;
    c = 13'h0000;
    ep = PC_CLEAR;
    es = 2'h1;
    ei = 1'b1;
    eq = 1'b0;
    if (e < 7) begin
        s = SM[e];
        c = CM[e];
        eq = 1'b1;
    end else if (e == 8) begin
        s = mode_idle ? 13'h0038 : 13'h0008;
        c = (!mode_idle && mode_sleep) ? 13'h0030 : 13'h0000;
        ep = wk ? PC_NEXT : PC_CLEAR;
        ei = !wk;
    end else if (e == 9) begin
        s = mode_idle ? 13'h0030 : 13'h0000;
        c = mode_idle ? 13'h0008 : (mode_sleep ? 13'h0038 : 13'h0000);
        ep = global_irq_enable ? PC_VECTOR : PC_NEXT;
        es = {1'b0, wk};
        ei = 1'b0;
    end else if (e == 16) begin
        s = mode_idle ? 13'h0022 : 13'h0002;
        c = mode_idle ? 13'h0018 : (mode_sleep ? 13'h0038 : 13'h0000);
    end else if (e == 10 || e == 11) begin
        s = (e == 10) ? 13'h0004 : 13'h0040;
    end else begin
        es = (e == 15) ? 2'h0 : 2'h1;
        ep = PC_NEXT;
        ei = 1'b0;
        c = (e == 12) ? 13'h0038 : ((e == 13) ? 13'h0008 : 13'h0000);
        s = (e == 13) ? 13'h0030 : ((e == 14) ? 13'h0010 : 13'h0000);
        if (e == 14 && (!wdt_window_en || wdt_in_safe_window)) c = 13'h0008;
    end
    ef = (e == 15) ? {cause_flags[12:11] & d[12:11], d[10:0]}
        : ((cause_flags & ~c) | s);
endfunction

// ========================================
// Stimulus tasks and main sequence
task automatic fire(int e, logic [12:0] d);
    int n;
    predict(e, d);
    sw_wr_data = d;
    if (e == 16) begin
        master_clear_pin_n = 1'b0;
        n = 0;
        while (pc_strobe !== 1'b1 && n < 8) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 8) begin
            miscompares++;
            close_out();
        end
    end else begin
        ev[e] = 1'b1;
        @(posedge clk_sys);
        #1;
        ev = 16'h0000;
    end
    if (e < 7) check("flags", cause_flags, ef);
    else check("flags", cause_flags, ef);
    if (es != 2'h2) check("strobe", {12'h000, pc_strobe}, {11'h000, es});
    if (es == 2'h1) check("pc", {11'h000, pc_action}, {11'h000, ep});
    check("init", {12'h000, regs_init}, {12'h000, ei});
    check("init_por", {12'h000, regs_init_por}, {12'h000, eq});
    if (e == 16) master_clear_pin_n = 1'b1;
    repeat ((e == 16) ? 4 : 1) @(posedge clk_sys);
    #1;
endtask

task automatic run_seq(logic [2:0] code, int lim, output int n);
    osc_select_field = code;
    sys_rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    #1;
    check("rst_flags", cause_flags, 13'h0F90);
    check("rst_hold", {12'h000, device_hold}, 13'h0001);
    sys_rst = 1'b0;
    n = 0;
    while (device_hold !== 1'b0 && n < lim) begin
        @(posedge clk_sys);
        #1;
        n++;
    end
    if (n >= 3000) begin
        miscompares++;
        close_out();
    end
endtask

initial begin
    seed = 32'hD1013884;
    compares = 0;
    miscompares = 0;
    osc_in = 1'b0;
    rc_osc_in = 1'b0;
    osc_run = 1'b1;
    master_clear_pin_n = 1'b1;
    {mode_idle, mode_sleep, global_irq_enable} = 3'h0;
    {wdt_window_en, wdt_in_safe_window} = 2'h0;
    ev = 16'h0000;
    sw_wr_data = 13'h0000;
    for (int c = 0; c < 8; c++) begin
        run_seq(c[2:0], 3000, tc[c]);
        ev[7] = 1'b1;
        @(posedge clk_sys);
        #1;
        ev[7] = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        check("pm_hold", {12'h000, device_hold}, {12'h000, c < 4});
    end
    for (int c = 0; c < 8; c++) begin
        if (c != 3) check("seq_len", tc[c][12:0], tc[c < 4 ? 2 : 5][12:0]);
    end
    check("powerup_timer", {12'h000, tc[5] >= 2 * PW}, 13'h0001);
    check("ost", {12'h000, (tc[2] - tc[5]) inside {[2 * OL - 2:2 * OL + 6]}},
        13'h0001);
    check("pll", {12'h000, (tc[3] - tc[2]) inside {[PL:PL + 4]}},
        13'h0001);
    osc_run = 1'b0;
    run_seq(3'h2, 200, t);
    check("osc_stall", {12'h000, device_hold}, 13'h0001);
    osc_run = 1'b1;
    run_seq(3'h2, 3000, t);
    $display("test sequencer done");
    for (int i = 0; i < 48; i++) begin
        {global_irq_enable, mode_idle, mode_sleep} = i[2:0];
        {wdt_window_en, wdt_in_safe_window} = {i[0], i[1]};
        fire(EL[i / 8], 13'h0000);
    end
    fire(15, 13'h1FFF);
    fire(15, 13'h0000);
    fire(4, 13'h0000);
    fire(15, 13'h1FFF);
    fire(15, 13'h0000);
    $display("test corner events done");
    for (int i = 0; i < 300; i++) begin
        t = $random(seed);
        {mode_idle, mode_sleep, global_irq_enable} = t[2:0];
        {wdt_window_en, wdt_in_safe_window} = t[4:3];
        fire((t[15:8] % 17 == 7) ? 15 : t[15:8] % 17, t[28:16]);
    end
    $display("test random events done");
    close_out();
end

endmodule
